// file: hw/pbts_target_seq.v
// What this block does
// R1: All bus signals sampled on rising clock edge.
// R2: Idle or turnaround: FRAME# asserted moves to busy.
// R3: Busy stays while FRAME# asserted or decode pending.
// R4: Busy idles on FRAME# off with decode done/DEVSEL#.
// R5: Late hit enters data, or retreat if terminating.
// R6: Data state holds under listed FRAME#/STOP#/TRDY# combinations.
// R7: Data leaves to turnaround or retreat as listed.
// R8: Retreat waits for FRAME# release, then turnaround.
// R9: Lock machine locks on hit with LOCK# deasserted.
// R10: Locked frees when FRAME# and LOCK# both deasserted.
// R11: Locked target retries unless LOCK# was deasserted.
// R12: Lock logic only acts when configured as bridge.
// R13: AD drivers on reads, data/retreat, after turnaround delay.
// R14: TRDY#/STOP#/DEVSEL# drivers on in retreat/data/turnaround.
// R15: PAR enable follows AD enable one clock later.
// R16: PERR# carries report pulse, enable one extra clock.
// R17: TRDY# only in data, ready, no abort, command allows.
// R18: STOP# in retreat, and data on abort or terminate.
// R19: DEVSEL# in retreat and data unless target abort.
// R20: PAR is even parity over AD and C/BE#.
// R21: Special cycles enable none of the response drivers.
// R22: Target machine independent of any initiator machine.
// R23: Terminate on conflict or too many wait states.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pbts_defines.vh"

module pbts_target_seq #(
	parameter WLIM_W = 8
) (
	// Clock, reset and clock enable.
	input  wire        CLK_I,
	input  wire        RESETN_I,
	input  wire        CE_I,
	// Bus pins sampled from the shared bus, all active low.
	input  wire        FRAME_N_I,
	input  wire        IRDY_N_I,
	input  wire        LOCK_N_I,
	input  wire        DEVSEL_N_I,
	input  wire [3:0]  CBE_N_I,
	// Bus pins driven by this target; enables are active low.
	output wire        TRDY_N_O,
	output wire        STOP_N_O,
	output wire        DEVSEL_N_O,
	output wire        RESP_OE_N_O,
	output wire [31:0] AD_O,
	output wire        AD_OE_N_O,
	output wire        PAR_O,
	output wire        PAR_OE_N_O,
	output wire        PERR_N_O,
	output wire        PERR_OE_N_O,
	// Backend indications, same clock.
	input  wire        HIT_I,
	input  wire        DECODE_DONE_I,
	input  wire        READY_I,
	input  wire        TERM_I,
	input  wire        TABORT_I,
	input  wire        CMD_READ_I,
	input  wire        CMD_WRITE_I,
	input  wire        SPECIAL_I,
	input  wire        TAR_DLY_I,
	input  wire        REPORT_PERR_I,
	input  wire [31:0] RD_DATA_I,
	// Backend status.
	output wire        XFER_O,
	output wire        LOCKED_O,
	// AXI4-Lite write address and data.
	input  wire [11:0] S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	// AXI4-Lite write response.
	output wire [1:0]  S_AXI_BRESP,
	output wire        S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	// AXI4-Lite read channels.
	input  wire [11:0] S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0]  S_AXI_RRESP,
	output wire        S_AXI_RVALID,
	input  wire        S_AXI_RREADY
);

	// Even parity of a 36-bit vector: the bit that makes the count of ones even.
	function par36;
		input [35:0] v;
		begin
			par36 = ^v;
		end
	endfunction

	// Three-stage synchroniser for the eight sampled bus lines.
	reg  [7:0]        s1_ff;           // First stage, read only by the second.
	reg  [7:0]        s2_ff;           // Second stage.
	reg  [7:0]        s3_ff;           // Third stage.
	reg  [7:0]        pin_ff;          // Accepted pin levels.
	// Sequencer and lock state.
	reg  [2:0]        state_ff;        // Target sequencer state.
	reg  [2:0]        nxt_state;       // Next sequencer state.
	reg               locked_ff;       // Lock machine: 1 means locked.
	reg               nxt_locked;      // Next lock state.
	reg               llock_n_ff;      // LOCK# caught in the address phase.
	reg               frame_d_ff;      // FRAME# of the previous edge.
	// Registered bus outputs.
	reg               trdy_n_ff;       // TRDY# drive level.
	reg               stop_n_ff;       // STOP# drive level.
	reg               devsel_n_ff;     // DEVSEL# drive level.
	reg               resp_oe_n_ff;    // Shared enable of the three above.
	reg  [31:0]       ad_ff;           // Read data driven on AD.
	reg               ad_oe_n_ff;      // AD enable.
	reg               par_ff;          // Parity line.
	reg               par_oe_n_ff;     // Parity enable.
	reg               perr_n_ff;       // PERR# drive level.
	reg               perr_oe_n_ff;    // PERR# enable.
	reg               perr_d_ff;       // Report pulse delayed one clock.
	reg               xfer_ff;         // Data phase completed this edge.
	// Wait state counter for self-termination.
	reg  [WLIM_W-1:0] wait_ff;         // Wait states in the current data phase.
	// Register file and AXI handshake state.
	reg  [31:0]       ctrl_ff;         // Control register.
	reg               aw_ff;           // Write address held.
	reg               w_ff;            // Write data held.
	reg  [11:0]       awaddr_ff;       // Held write address.
	reg  [31:0]       wdata_ff;        // Held write data.
	reg  [3:0]        wstrb_ff;        // Held write strobes.
	reg               bvalid_ff;       // Write response pending.
	reg  [1:0]        bresp_ff;        // Write response code.
	reg               rvalid_ff;       // Read data pending.
	reg  [1:0]        rresp_ff;        // Read response code.
	reg  [31:0]       rdata_ff;        // Read data.

	// Decoded views of the accepted pins; 1 means asserted, except cbe_n, which keeps the pin level.
	wire              frame_a  = ~pin_ff[0];
	wire              irdy_a   = ~pin_ff[1];
	wire              lock_a   = ~pin_ff[2];
	wire              devsel_a = ~pin_ff[3];
	wire [3:0]        cbe_n    = pin_ff[7:4];
	// Our own driven levels serve as TRDY# and STOP# in the equations.
	wire              trdy_a   = ~trdy_n_ff;
	wire              stop_a   = ~stop_n_ff;
	// Configuration fields.
	wire              lock_en  = ctrl_ff[`PBTS_CTRL_LOCK_EN];
	wire              spc_en   = ctrl_ff[`PBTS_CTRL_SPC_EN];
	wire [WLIM_W-1:0] wlim     = ctrl_ff[`PBTS_CTRL_WLIM_LO +: WLIM_W];
	// A special cycle only masks drivers when support is switched on.
	wire              spc_mask = spc_en & SPECIAL_I;
	// Locked target retries unless LOCK# was deasserted in the address phase.
	wire              retry    = lock_en & locked_ff & ~llock_n_ff; // [R11] [R12]
	// Termination: backend request, too many waits, or a lock retry.
	wire              wlim_hit = (wlim != {WLIM_W{1'b0}}) & (wait_ff >= wlim);
	wire              term     = TERM_I | wlim_hit | retry; // [R23]
	// A retry never moves data, so ready is masked for it.
	wire              ready    = READY_I & ~retry;
	wire              cmd_ok   = CMD_WRITE_I | (CMD_READ_I & TAR_DLY_I);

	// The synchroniser accepts a change once stages two and three agree.
	always @(posedge CLK_I) begin // [R1]
		if (!RESETN_I) begin
			s1_ff  <= 8'hFF;
			s2_ff  <= 8'hFF;
			s3_ff  <= 8'hFF;
			pin_ff <= 8'hFF;
		end else if (CE_I) begin
			s1_ff  <= {CBE_N_I, DEVSEL_N_I, LOCK_N_I, IRDY_N_I, FRAME_N_I};
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			// Stages that disagree hold the old level, so a glitch is never taken.
			pin_ff <= (pin_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));
		end
	end

	// Next state of the target sequencer. It looks only at bus pins, the backend
	// and its own wait count, lock state and configuration, never at an initiator, so a combined agent cannot deadlock.
	always @* begin // [R22]
		nxt_state = state_ff;
		case (state_ff)
			`PBTS_ST_IDLE, `PBTS_ST_TURN: begin
				// Medium decode: any new frame is judged in busy.
				if (frame_a)
					nxt_state = `PBTS_ST_BUSY; // [R2]
				else
					nxt_state = `PBTS_ST_IDLE; // [R2]
			end
			`PBTS_ST_BUSY: begin
				if (HIT_I && (frame_a || irdy_a)) begin
					if (!term || ready)
						nxt_state = `PBTS_ST_DATA; // [R5]
					else
						nxt_state = `PBTS_ST_RETREAT; // [R5]
				end else if (frame_a || !DECODE_DONE_I) begin
					// A pending decode may still be ended by another claimer.
					if (!frame_a && devsel_a)
						nxt_state = `PBTS_ST_IDLE; // [R4]
					else
						nxt_state = `PBTS_ST_BUSY; // [R3]
				end else begin
					nxt_state = `PBTS_ST_IDLE; // [R4]
				end
			end
			`PBTS_ST_DATA: begin
				if (frame_a && stop_a && (!trdy_a || irdy_a))
					nxt_state = `PBTS_ST_RETREAT; // [R7]
				else if (!frame_a && (trdy_a || stop_a))
					nxt_state = `PBTS_ST_TURN; // [R7]
				else
					nxt_state = `PBTS_ST_DATA; // [R6]
			end
			`PBTS_ST_RETREAT: begin
				if (frame_a)
					nxt_state = `PBTS_ST_RETREAT; // [R8]
				else
					nxt_state = `PBTS_ST_TURN; // [R8]
			end
			default: begin
				nxt_state = `PBTS_ST_IDLE;
			end
		endcase
	end

	// Next lock state; the whole machine is held free unless bridging.
	always @* begin
		nxt_locked = locked_ff;
		if (!lock_en) begin
			nxt_locked = 1'b0; // [R12]
		end else if (!locked_ff) begin
			if (HIT_I && frame_a && !lock_a &&
			    (state_ff == `PBTS_ST_IDLE || state_ff == `PBTS_ST_TURN))
				nxt_locked = 1'b1; // [R9]
			else if (HIT_I && llock_n_ff && state_ff == `PBTS_ST_BUSY)
				nxt_locked = 1'b1; // [R9]
		end else if (!frame_a && !lock_a) begin
			nxt_locked = 1'b0; // [R10]
		end
	end

	// State, lock and address-phase capture.
	always @(posedge CLK_I) begin // [R1]
		if (!RESETN_I) begin
			state_ff   <= `PBTS_ST_IDLE;
			locked_ff  <= 1'b0;
			llock_n_ff <= 1'b1;
			frame_d_ff <= 1'b0;
		end else if (CE_I) begin
			state_ff   <= nxt_state;
			locked_ff  <= nxt_locked;
			frame_d_ff <= frame_a;
			// The first edge with FRAME# asserted is the address phase.
			if (frame_a && !frame_d_ff)
				llock_n_ff <= ~lock_a; // [R9]
		end
	end

	// TRDY#, STOP#, DEVSEL# and the response and AD enables follow the next state so they are valid on state entry.
	// The shared response enable stays on in turnaround so the lines are
	// driven high for one clock before release.
	always @(posedge CLK_I) begin
		if (!RESETN_I) begin
			trdy_n_ff    <= 1'b1;
			stop_n_ff    <= 1'b1;
			devsel_n_ff  <= 1'b1;
			resp_oe_n_ff <= 1'b1;
			ad_ff        <= 32'h0000_0000;
			ad_oe_n_ff   <= 1'b1;
			par_ff       <= 1'b0;
			par_oe_n_ff  <= 1'b1;
			perr_n_ff    <= 1'b1;
			perr_oe_n_ff <= 1'b1;
			perr_d_ff    <= 1'b0;
			xfer_ff      <= 1'b0;
		end else if (CE_I) begin
			trdy_n_ff    <= ~(nxt_state == `PBTS_ST_DATA && ready &&
			                  !TABORT_I && cmd_ok); // [R17]
			stop_n_ff    <= ~(nxt_state == `PBTS_ST_RETREAT ||
			                  (nxt_state == `PBTS_ST_DATA && (TABORT_I || term))); // [R18]
			devsel_n_ff  <= ~((nxt_state == `PBTS_ST_RETREAT ||
			                   nxt_state == `PBTS_ST_DATA) && !TABORT_I); // [R19]
			resp_oe_n_ff <= ~((nxt_state == `PBTS_ST_RETREAT || nxt_state == `PBTS_ST_DATA ||
			                   nxt_state == `PBTS_ST_TURN) && !spc_mask); // [R14] [R21]
			ad_ff        <= RD_DATA_I;
			ad_oe_n_ff   <= ~((nxt_state == `PBTS_ST_DATA || nxt_state == `PBTS_ST_RETREAT) &&
			                  TAR_DLY_I && CMD_READ_I && !spc_mask); // [R13] [R21]
			// Parity trails the AD lines it covers by one clock.
			par_ff       <= par36({ad_ff, cbe_n}); // [R20]
			par_oe_n_ff  <= ad_oe_n_ff; // [R15]
			perr_d_ff    <= REPORT_PERR_I;
			perr_n_ff    <= ~REPORT_PERR_I; // [R16]
			perr_oe_n_ff <= ~((REPORT_PERR_I || perr_d_ff) && !spc_mask); // [R16] [R21]
			xfer_ff      <= (state_ff == `PBTS_ST_DATA) && trdy_a && irdy_a;
		end
	end

	// Wait states: clock edges in data with no transfer; clears on transfer.
	always @(posedge CLK_I) begin
		if (!RESETN_I) begin
			wait_ff <= {WLIM_W{1'b0}};
		end else if (CE_I) begin
			if (state_ff != `PBTS_ST_DATA || (trdy_a && irdy_a))
				wait_ff <= {WLIM_W{1'b0}};
			else if (wait_ff != {WLIM_W{1'b1}})
				wait_ff <= wait_ff + {{(WLIM_W-1){1'b0}}, 1'b1}; // [R23]
		end
	end

	// AXI4-Lite write path: address and data are taken in either order,
	// then written together and answered on the same clock.
	always @(posedge CLK_I) begin
		if (!RESETN_I) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PBTS_RESP_OKAY;
			ctrl_ff   <= `PBTS_CTRL_RST;
		end else if (CE_I) begin
			if (S_AXI_AWVALID && !aw_ff && !bvalid_ff) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_ff && !bvalid_ff) begin
				w_ff     <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
				wstrb_ff <= S_AXI_WSTRB;
			end
			if (aw_ff && w_ff) begin
				aw_ff     <= 1'b0;
				w_ff      <= 1'b0;
				bvalid_ff <= 1'b1;
				if ({awaddr_ff[11:2], 2'b00} == `PBTS_OFS_CTRL) begin
					bresp_ff <= `PBTS_RESP_OKAY;
					if (wstrb_ff[0]) ctrl_ff[7:0]   <= wdata_ff[7:0];
					if (wstrb_ff[1]) ctrl_ff[15:8]  <= wdata_ff[15:8];
				end else if ({awaddr_ff[11:2], 2'b00} == `PBTS_OFS_STATUS) begin
					// Status is read-only; writes are accepted and dropped.
					bresp_ff <= `PBTS_RESP_OKAY;
				end else begin
					bresp_ff <= `PBTS_RESP_DECERR;
				end
			end else if (bvalid_ff && S_AXI_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path: one read at a time, data one clock after address.
	always @(posedge CLK_I) begin
		if (!RESETN_I) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `PBTS_RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else if (CE_I) begin
			if (S_AXI_ARVALID && !rvalid_ff) begin
				rvalid_ff <= 1'b1;
				rresp_ff  <= `PBTS_RESP_OKAY;
				rdata_ff  <= 32'h0000_0000;
				if ({S_AXI_ARADDR[11:2], 2'b00} == `PBTS_OFS_CTRL) begin
					rdata_ff[15:0] <= ctrl_ff[15:0];
				end else if ({S_AXI_ARADDR[11:2], 2'b00} == `PBTS_OFS_STATUS) begin
					rdata_ff[`PBTS_STAT_STATE_HI:`PBTS_STAT_STATE_LO] <= state_ff;
					rdata_ff[`PBTS_STAT_LOCKED] <= locked_ff;
					rdata_ff[`PBTS_STAT_LLOCK]  <= llock_n_ff;
				end else begin
					rresp_ff <= `PBTS_RESP_DECERR;
				end
			end else if (rvalid_ff && S_AXI_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Port drives, straight from flip-flops except ARREADY, which inverts one, and AWREADY and WREADY, which each combine two flip-flops.
	assign TRDY_N_O      = trdy_n_ff;
	assign STOP_N_O      = stop_n_ff;
	assign DEVSEL_N_O    = devsel_n_ff;
	assign RESP_OE_N_O   = resp_oe_n_ff;
	assign AD_O          = ad_ff;
	assign AD_OE_N_O     = ad_oe_n_ff;
	assign PAR_O         = par_ff;
	assign PAR_OE_N_O    = par_oe_n_ff;
	assign PERR_N_O      = perr_n_ff;
	assign PERR_OE_N_O   = perr_oe_n_ff;
	assign XFER_O        = xfer_ff;
	assign LOCKED_O      = locked_ff;
	assign S_AXI_AWREADY = ~aw_ff & ~bvalid_ff;
	assign S_AXI_WREADY  = ~w_ff & ~bvalid_ff;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = bresp_ff;
	assign S_AXI_ARREADY = ~rvalid_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RRESP   = rresp_ff;
	assign S_AXI_RDATA   = rdata_ff;

endmodule // pbts_target_seq

`default_nettype wire

// file: pkg/pbts_defines.vh
`ifndef PBTS_DEFINES_VH
`define PBTS_DEFINES_VH

// Register byte offsets on the AXI4-Lite port.
`define PBTS_OFS_CTRL       12'h000
`define PBTS_OFS_STATUS     12'h004

// Control register field positions.
`define PBTS_CTRL_LOCK_EN   0
`define PBTS_CTRL_SPC_EN    1
`define PBTS_CTRL_WLIM_LO   8
`define PBTS_CTRL_WLIM_HI   15

// Control register reset value: lock off, special cycles off, wait limit 16.
`define PBTS_CTRL_RST       32'h0000_1000

// Status register field positions.
`define PBTS_STAT_STATE_LO  0
`define PBTS_STAT_STATE_HI  2
`define PBTS_STAT_LOCKED    4
`define PBTS_STAT_LLOCK     5

// AXI response codes.
`define PBTS_RESP_OKAY      2'h0
`define PBTS_RESP_DECERR    2'h3

// Target sequencer state codes.
`define PBTS_ST_IDLE        3'h0
`define PBTS_ST_BUSY        3'h1
`define PBTS_ST_DATA        3'h2
`define PBTS_ST_RETREAT     3'h3
`define PBTS_ST_TURN        3'h4

`endif

// file: testbench/pbts_target_seq_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pbts_target_seq_checker (
	// Clock and reset.
	input wire logic        CLK_I,
	input wire logic        RESETN_I,
	// Watched inputs.
	input wire logic [3:0]  CBE_N_I,
	input wire logic        READY_I,
	input wire logic        TABORT_I,
	input wire logic        CMD_READ_I,
	input wire logic        TAR_DLY_I,
	input wire logic        REPORT_PERR_I,
	input wire logic        SPECIAL_I,
	// Watched outputs.
	input wire logic        TRDY_N_O,
	input wire logic        STOP_N_O,
	input wire logic        DEVSEL_N_O,
	input wire logic        RESP_OE_N_O,
	input wire logic [31:0] AD_O,
	input wire logic        AD_OE_N_O,
	input wire logic        PAR_O,
	input wire logic        PAR_OE_N_O,
	input wire logic        PERR_N_O,
	input wire logic        PERR_OE_N_O,
	input wire logic        XFER_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Parity is judged only once C/BE# has been quiet long enough to clear the synchroniser.
	logic [2:0] cq_ff;    // Quiet cycle count of C/BE#.
	logic [3:0] cbe_d_ff; // Last seen C/BE#.
	// Count cycles without a change of C/BE#.
	always @(posedge CLK_I) begin
		cbe_d_ff <= CBE_N_I;
		if (!RESETN_I || CBE_N_I != cbe_d_ff) begin
			cq_ff <= 3'h0;
		end else if (cq_ff != 3'h7) begin
			cq_ff <= cq_ff + 3'h1;
		end
	end
	property p_par_oe; PAR_OE_N_O == $past(AD_OE_N_O); endproperty
	a_par_oe: assert property (p_par_oe) else $error("parity enable does not trail data enable");
	property p_perr; REPORT_PERR_I |=> !PERR_N_O && !PERR_OE_N_O ##1 !PERR_OE_N_O; endproperty
	a_perr: assert property (p_perr) else $error("parity error report not driven");
	property p_perr_src; !PERR_N_O |-> $past(REPORT_PERR_I); endproperty
	a_perr_src: assert property (p_perr_src) else $error("parity error line low without report");
	property p_trdy; !TRDY_N_O |-> $past(READY_I && !TABORT_I); endproperty
	a_trdy: assert property (p_trdy) else $error("ready asserted without backend ready");
	property p_devsel; !DEVSEL_N_O |-> !$past(TABORT_I); endproperty
	a_devsel: assert property (p_devsel) else $error("select asserted during target abort");
	property p_ad_oe; !AD_OE_N_O |-> $past(CMD_READ_I && TAR_DLY_I) && !RESP_OE_N_O; endproperty
	a_ad_oe: assert property (p_ad_oe) else $error("data drivers on outside a read");
	// A masked special cycle keeps its levels but never enables the drivers.
	property p_lines_oe; (!TRDY_N_O || !STOP_N_O || !DEVSEL_N_O) && !$past(SPECIAL_I) |-> !RESP_OE_N_O; endproperty
	a_lines_oe: assert property (p_lines_oe) else $error("response line active while released");
	property p_release; $rose(RESP_OE_N_O) |-> $past(TRDY_N_O && STOP_N_O && DEVSEL_N_O); endproperty
	a_release: assert property (p_release) else $error("response lines released while active");
	property p_xfer; XFER_O |-> $past(!TRDY_N_O); endproperty
	a_xfer: assert property (p_xfer) else $error("transfer reported without ready");
	property p_par; cq_ff >= 3'h5 |-> PAR_O == ^{$past(AD_O), CBE_N_I}; endproperty
	a_par: assert property (p_par) else $error("parity is not even");
	c_xfer: cover property (XFER_O);
	c_abort: cover property (!STOP_N_O && DEVSEL_N_O);
	c_ad_oe: cover property (!AD_OE_N_O);
	c_perr: cover property (!PERR_N_O);
endmodule // pbts_target_seq_checker
bind pbts_target_seq pbts_target_seq_checker u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CBE_N_I(CBE_N_I),
	.READY_I(READY_I), .TABORT_I(TABORT_I), .CMD_READ_I(CMD_READ_I), .TAR_DLY_I(TAR_DLY_I), .SPECIAL_I(SPECIAL_I),
	.REPORT_PERR_I(REPORT_PERR_I), .TRDY_N_O(TRDY_N_O), .STOP_N_O(STOP_N_O), .DEVSEL_N_O(DEVSEL_N_O),
	.RESP_OE_N_O(RESP_OE_N_O), .AD_O(AD_O), .AD_OE_N_O(AD_OE_N_O), .PAR_O(PAR_O), .PAR_OE_N_O(PAR_OE_N_O),
	.PERR_N_O(PERR_N_O), .PERR_OE_N_O(PERR_OE_N_O), .XFER_O(XFER_O));
`default_nettype wire

// file: testbench/pbts_initiator_model.sv
`timescale 1ns/1ns
`default_nettype none
module pbts_initiator_model (
	// Clock and request from the bench.
	input wire logic       clk_i,
	input wire logic       go_i,
	input wire logic [3:0] wt_i,
	// Target answers.
	input wire logic       trdy_n_i,
	input wire logic       stop_n_i,
	// Initiator drives.
	output logic           frame_n_o = 1'b1,
	output logic           irdy_n_o = 1'b1,
	output logic [3:0]     cbe_n_o = 4'hF,
	output logic           done_o = 1'b0
);
	int n; // Bounded wait count, serves both the ready/stop wait and the release wait.
	// One transaction per request; all sampling is at the rising edge.
	always begin
		@(posedge clk_i);
		if (go_i === 1'b1) begin
			frame_n_o <= 1'b0;
			cbe_n_o <= 4'h6;
			// The address phase lasts one clock; a slow initiator then holds off its ready for wt_i clocks.
			@(posedge clk_i);
			repeat (wt_i) @(posedge clk_i);
			irdy_n_o <= 1'b0;
			cbe_n_o <= 4'h0;
			n = 0;
			while (trdy_n_i && stop_n_i && n < 12) begin
				@(posedge clk_i);
				n = n + 1;
			end
			// Ending the frame on ready, stop or timeout; stop always leads here.
			frame_n_o <= 1'b1;
			n = 0;
			while ((!trdy_n_i || !stop_n_i) && n < 12) begin
				@(posedge clk_i);
				n = n + 1;
			end
			// Released C/BE# goes to its pull-up level.
			irdy_n_o <= 1'b1;
			cbe_n_o <= 4'hF;
			done_o <= 1'b1;
			@(posedge clk_i);
			done_o <= 1'b0;
		end
	end
endmodule // pbts_initiator_model
`default_nettype wire

// file: testbench/pbts_target_seq_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "pbts_defines.vh"
module pbts_target_seq_bench;
	logic clk = 1'b0, rstn = 1'b0, go = 1'b0, lock_n = 1'b1, perr = 1'b0, spc = 1'b0;
	logic hit = 1'b1, dd = 1'b1, rdy = 1'b1, term = 1'b0, tab = 1'b0, crd = 1'b1, tdly = 1'b1;
	logic [3:0] wtr = 4'h0, cbe_n;
	logic [31:0] rdd = 32'hA5C3_0F96, ad, wdata = 32'h0, rdata;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, awr, wr, bv, arr, rv;
	logic [1:0] bresp, rresp;
	logic frame_n, irdy_n, done, trdy_n, stop_n, devsel_n, resp_oe_n, ad_oe_n, par, par_oe_n;
	logic perr_n, perr_oe_n, xfer, locked;
	logic s_trdy, s_stop, s_dev, s_oe, s_adoe, s_xfer; // What the target showed in one transaction.
	int fail_count = 0, compares = 0;
	always #4 clk = ~clk;
	pbts_initiator_model u_init (.clk_i(clk), .go_i(go), .wt_i(wtr), .trdy_n_i(trdy_n), .stop_n_i(stop_n),
		.frame_n_o(frame_n), .irdy_n_o(irdy_n), .cbe_n_o(cbe_n), .done_o(done));
	// The other agent's select stays at its pull-up level; the clock enable stays on.
	pbts_target_seq uut (.CLK_I(clk), .RESETN_I(rstn), .CE_I(1'b1), .FRAME_N_I(frame_n), .IRDY_N_I(irdy_n),
		.LOCK_N_I(lock_n), .DEVSEL_N_I(1'b1), .CBE_N_I(cbe_n), .TRDY_N_O(trdy_n), .STOP_N_O(stop_n),
		.DEVSEL_N_O(devsel_n), .RESP_OE_N_O(resp_oe_n), .AD_O(ad), .AD_OE_N_O(ad_oe_n), .PAR_O(par),
		.PAR_OE_N_O(par_oe_n), .PERR_N_O(perr_n), .PERR_OE_N_O(perr_oe_n), .HIT_I(hit), .DECODE_DONE_I(dd),
		.READY_I(rdy), .TERM_I(term), .TABORT_I(tab), .CMD_READ_I(crd), .CMD_WRITE_I(!crd), .SPECIAL_I(spc),
		.TAR_DLY_I(tdly), .REPORT_PERR_I(perr), .RD_DATA_I(rdd), .XFER_O(xfer), .LOCKED_O(locked),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	// Collect what the target drove during the current transaction.
	always @(posedge clk) begin
		s_trdy |= trdy_n === 1'b0;
		s_stop |= stop_n === 1'b0;
		s_dev |= devsel_n === 1'b0;
		s_oe |= resp_oe_n === 1'b0 || ad_oe_n === 1'b0 || par_oe_n === 1'b0;
		s_adoe |= ad_oe_n === 1'b0;
		s_xfer |= xfer === 1'b1;
	end
	task close_out;
		begin
			$display("Comparisons %0d, mismatches %0d", compares, fail_count);
			if (fail_count == 0 && compares > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		begin
			compares++;
			if (got !== exp) begin
				fail_count++;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task chk_flag(input logic got, input logic exp);
		begin
			compares++;
			if (got !== exp) begin
				fail_count++;
				$display("Error at %0t: flag got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// A wait that runs out of its bound ends the run as a mismatch.
	task give_up(input int i);
		begin
			if (i >= 50) begin
				fail_count++;
				close_out();
			end
		end
	endtask
	task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		begin
			awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
			for (i = 0; i < 50; i++) begin
				@(posedge clk);
				if (awv && awr === 1'b1) awv <= 1'b0;
				if (wv && wr === 1'b1) wv <= 1'b0;
				if (bv === 1'b1) break;
			end
			give_up(i);
			br <= 1'b0;
			chk_val({30'h0, bresp}, {30'h0, er});
			@(posedge clk);
		end
	endtask
	task axi_rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
		int i;
		begin
			araddr <= a; arv <= 1'b1; rr <= 1'b1;
			for (i = 0; i < 50; i++) begin
				@(posedge clk);
				if (arv && arr === 1'b1) arv <= 1'b0;
				if (rv === 1'b1) break;
			end
			give_up(i);
			rr <= 1'b0;
			chk_val(rdata & m, exp);
			chk_val({30'h0, rresp}, {30'h0, er});
			@(posedge clk);
		end
	endtask
	// One initiator transaction, then time for the lagging pin sampling to return to idle.
	task run(input logic [3:0] wt);
		int i;
		begin
			{s_trdy, s_stop, s_dev, s_oe, s_adoe, s_xfer} = 6'h0;
			wtr <= wt; go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk);
			give_up(i / 2);
			repeat (8) @(posedge clk);
		end
	endtask
	task scen(input logic h, r, t, a, et, es, ed);
		begin
			hit <= h; rdy <= r; term <= t; tab <= a;
			run(4'h0);
			chk_flag(s_trdy, et);
			chk_flag(s_stop, es);
			chk_flag(s_dev, ed);
		end
	endtask
	initial begin : main
		int k;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		axi_rd(`PBTS_OFS_CTRL, `PBTS_CTRL_RST, 32'hFFFF_FFFF, `PBTS_RESP_OKAY);
		axi_wr(`PBTS_OFS_STATUS, 32'hFFFF_FFFF, `PBTS_RESP_OKAY);
		axi_rd(`PBTS_OFS_STATUS, {29'h0, `PBTS_ST_IDLE}, 32'h0000_0017, `PBTS_RESP_OKAY);
		axi_wr(12'h010, 32'h0000_0001, `PBTS_RESP_DECERR);
		axi_rd(12'h010, 32'h0, 32'hFFFF_FFFF, `PBTS_RESP_DECERR);
		axi_wr(`PBTS_OFS_CTRL, 32'hFFFF_1000, `PBTS_RESP_OKAY);
		axi_rd(`PBTS_OFS_CTRL, 32'h0000_1000, 32'hFFFF_FFFF, `PBTS_RESP_OKAY);
		for (k = 0; k < 2; k++) begin
			crd <= k[0];
			scen(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
			chk_flag(s_adoe, k[0]);
			chk_flag(s_xfer, 1'b1);
		end
		chk_val(ad, rdd);
		run(4'h3);
		chk_flag(s_xfer, 1'b1);
		scen(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		scen(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		scen(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		scen(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk_flag(s_oe, 1'b0);
		axi_wr(`PBTS_OFS_CTRL, 32'h0000_0200, `PBTS_RESP_OKAY);
		scen(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		axi_wr(`PBTS_OFS_CTRL, 32'h0000_1002, `PBTS_RESP_OKAY);
		spc <= 1'b1;
		scen(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		chk_flag(s_oe, 1'b0);
		spc <= 1'b0;
		for (k = 0; k < 2; k++) begin
			axi_wr(`PBTS_OFS_CTRL, 32'h0000_1000 | k, `PBTS_RESP_OKAY);
			// Lock is taken after the address phase, so the target latched it released.
			fork
				run(4'h4);
				begin repeat (4) @(posedge clk); lock_n <= 1'b0; end
			join
			chk_flag(locked, k[0]);
			axi_rd(`PBTS_OFS_STATUS, {27'h0, k[0], 4'h0}, 32'h0000_0010, `PBTS_RESP_OKAY);
			scen(1'b1, 1'b1, 1'b0, 1'b0, !k[0], k[0], 1'b1);
			chk_flag(locked, k[0]);
			lock_n <= 1'b1;
			repeat (6) @(posedge clk);
			chk_flag(locked, 1'b0);
		end
		perr <= 1'b1;
		@(posedge clk);
		perr <= 1'b0;
		@(posedge clk);
		chk_flag(perr_n, 1'b0);
		chk_flag(perr_oe_n, 1'b0);
		@(posedge clk);
		chk_flag(perr_oe_n, 1'b0);
		close_out();
	end
endmodule // pbts_target_seq_bench
`default_nettype wire
